// ### src/wwd_pkg.sv
package wwd_pkg;
  // ==========================================================================
  // Register map and field layout of the service register.
  // ==========================================================================
  localparam logic [3:0] ADDR_SERVICE = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam int WIN_MSB = 7;
  localparam int WIN_LSB = 6;
  localparam int KEY_MSB = 5;
  localparam int KEY_LSB = 1;
  localparam int CMON_BIT = 0;
  localparam logic [4:0] KEY_VALUE = 5'h0c;
  localparam logic [1:0] WIN_RESET = 2'h3;
  localparam logic CMON_RESET = 1'b1;

  // ==========================================================================
  // Window limits in idle-timer clocks.
  // ==========================================================================
  localparam logic [16:0] LOWER_LIMIT = 17'h00800;
  localparam logic [16:0] UPPER_8K = 17'h02000;
  localparam logic [16:0] UPPER_16K = 17'h04000;
  localparam logic [16:0] UPPER_32K = 17'h08000;
  localparam logic [16:0] UPPER_64K = 17'h10000;

  // ==========================================================================
  // Clock monitor: the instruction clock must rise within this many
  // system clocks. 10 Hz rejection at 100 MHz is 10,000,000 cycles.
  // ==========================================================================
  localparam int CMON_TIMEOUT_MS = 100;
  localparam int SYS_CLK_KHZ = 100000;
  localparam int CMON_TIMEOUT_CYCLES = CMON_TIMEOUT_MS * SYS_CLK_KHZ;
  localparam logic [23:0] CMON_COUNT_ZERO = 24'h000000;
endpackage : wwd_pkg

// ### src/wwd_sync3.sv
`timescale 1ns/1ps
// Three-stage synchroniser; a change counts once stages two and three agree.
module wwd_sync3 (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_async,
  output logic o_level,
  output logic o_rise
);
  logic [2:0] stage;
  logic held;

  // ==========================================================================
  // Shift chain; the first stage feeds only the second.
  // ==========================================================================
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      stage <= 3'h0;
      held <= 1'b0;
    end else begin
      stage <= {stage[1:0], i_async};
      if (stage[1] == stage[2]) begin
        held <= stage[2];
      end
    end
  end

  // The rise pulse fires once per accepted low-to-high change.
  assign o_level = held;
  assign o_rise = (stage[1] == stage[2]) && stage[2] && !held;
endmodule : wwd_sync3

// ### src/wwd_core.sv
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// R1 - Only a full service-register write services
// R2 - Fields: window 7:6, key 5:1, monitor 0
// R3 - Key must equal 01100
// R4 - Lower limit fixed at 2048 clocks
// R5 - Window select picks 8k/16k/32k/64k upper
// R6 - Idle clock is instruction or 32 kHz
// R7 - Bit 0 disables or enables clock monitor
// R8 - All window timing counts idle-timer ticks
// R9 - Separate upper and lower limit counters
// R10 - Service before lower limit is error; the code exempts the first service after reset
// R11 - Monitor flags absent or slow instruction clock
// R12 - Watchdog inactive unless option selects it
// R13 - First keyed write fixes window and monitor
// R14 - Later writes must match all fields
// R15 - Reset arms with 64k window, monitor on
// R16 - Key field reads back as zeros
// R17 - Valid service restarts both counters
// R18 - Upper expiry raises watchdog error
module wwd_core
  import wwd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_watchdog_option,
  input wire logic i_low_speed_mode,
  input wire logic i_instr_clk,
  input wire logic i_lowspeed_clk,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [7:0] o_rdata,
  output logic o_watchdog_fault_output,
  output logic o_clock_fault
);

  // ==========================================================================
  // State.
  // ==========================================================================
  typedef struct packed {
    logic [1:0] win_sel;
    logic cmon_en;
    logic first_done;
    logic [16:0] upper_limit_counter;
    logic [11:0] lower_limit_counter;
    logic lower_open;
    logic [23:0] cmon_count;
    logic clock_fault;
    logic wd_fault;
    logic fault_out;
    logic [7:0] rdata;
  } wwd_state_type;

  wwd_state_type state;
  wwd_state_type next_state;

  logic instr_rise;
  logic ls_level;
  logic ls_rise;
  logic idle_tick;
  logic service_wr;
  logic key_ok;
  logic fields_ok;
  logic early;
  logic [16:0] upper_limit;
  logic upper_expired;
  logic valid_service;
  logic bad_service;

  // ==========================================================================
  // Pin inputs cross into the system clock through three flip-flops.
  // ==========================================================================
  wwd_sync3 u_sync_instr (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_async(i_instr_clk),
    .o_level(),
    .o_rise(instr_rise)
  );

  wwd_sync3 u_sync_ls (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_async(i_lowspeed_clk),
    .o_level(ls_level),
    .o_rise(ls_rise)
  );

  // ==========================================================================
  // Decode of a service write and selection of the idle-timer tick.
  // ==========================================================================
  always_comb begin
    idle_tick = i_low_speed_mode ? ls_rise : instr_rise; // R6 R8
    service_wr = i_write && (i_addr == ADDR_SERVICE); // R1
    key_ok = (i_wdata[KEY_MSB:KEY_LSB] == KEY_VALUE); // R2 R3
    fields_ok = key_ok && (i_wdata[WIN_MSB:WIN_LSB] == state.win_sel) // R14
      && (i_wdata[CMON_BIT] == state.cmon_en);
    // The very first service may fall inside the lower limit without error.
    early = state.first_done && !state.lower_open; // R10
    case (state.win_sel) // R5
      2'h0: upper_limit = UPPER_8K;
      2'h1: upper_limit = UPPER_16K;
      2'h2: upper_limit = UPPER_32K;
      default: upper_limit = UPPER_64K;
    endcase
    upper_expired = (state.upper_limit_counter >= upper_limit); // R18
    valid_service = service_wr && !state.wd_fault && !early
      && (state.first_done ? fields_ok : key_ok); // R13 R14
    // Services are ignored while the watchdog fault is already set.
    bad_service = service_wr && !state.wd_fault && !valid_service; // R10 R14
  end

  // ==========================================================================
  // Next-state logic.
  // ==========================================================================
  always_comb begin
    next_state = state;

    // Counters run on idle-timer ticks only; the upper saturates, the lower stops at 2048 as its window opens.
    if (idle_tick && !upper_expired) begin // R9
      next_state.upper_limit_counter = state.upper_limit_counter + 17'h00001;
    end
    if (idle_tick && !state.lower_open) begin // R4 R9
      next_state.lower_limit_counter = state.lower_limit_counter + 12'h001;
      if ({5'h00, state.lower_limit_counter} == LOWER_LIMIT[16:0] - 17'h00001) begin
        next_state.lower_open = 1'b1;
      end
    end

    if (valid_service) begin
      if (!state.first_done) begin // R13
        next_state.win_sel = i_wdata[WIN_MSB:WIN_LSB];
        next_state.cmon_en = i_wdata[CMON_BIT]; // R7
        next_state.first_done = 1'b1;
      end
      next_state.upper_limit_counter = 17'h00000; // R17
      next_state.lower_limit_counter = 12'h000; // R17
      next_state.lower_open = 1'b0;
    end

    // Fault is a level; it holds until reset or until the watchdog option is deselected.
    if (!i_watchdog_option) begin // R12
      next_state.wd_fault = 1'b0;
      next_state.upper_limit_counter = 17'h00000;
      next_state.lower_limit_counter = 12'h000;
      next_state.lower_open = 1'b0;
    end else if (bad_service || upper_expired) begin // R10 R14 R18
      next_state.wd_fault = 1'b1;
    end

    // Clock monitor: restart on every instruction-clock rising edge.
    if (instr_rise) begin // R11
      next_state.cmon_count = CMON_COUNT_ZERO;
      next_state.clock_fault = 1'b0;
    end else if (state.cmon_count == 24'(CMON_TIMEOUT_CYCLES - 1)) begin
      next_state.clock_fault = state.cmon_en; // R7 R11
    end else begin
      next_state.cmon_count = state.cmon_count + 24'h000001;
    end
    // Uses the next monitor enable, so a first write that disables it clears a standing fault at once.
    if (!next_state.cmon_en) begin // R7
      next_state.clock_fault = 1'b0;
    end

    // The pin output is a flop of its own, so it never glitches between the two fault sources.
    next_state.fault_out = next_state.wd_fault || next_state.clock_fault; // R11 R18

    // Read data stand one cycle after the strobe; key always reads zero.
    next_state.rdata = 8'h00;
    if (i_read) begin
      case (i_addr)
        ADDR_SERVICE: next_state.rdata = {state.win_sel, 5'h00, state.cmon_en}; // R16
        ADDR_STATUS: next_state.rdata = {4'h0, ls_level, state.first_done,
          state.clock_fault, state.wd_fault};
        default: next_state.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // State register.
  // ==========================================================================
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state <= '0;
      state.win_sel <= WIN_RESET; // R15
      state.cmon_en <= CMON_RESET; // R15
    end else begin
      state <= next_state;
    end
  end

  assign o_rdata = state.rdata;
  assign o_watchdog_fault_output = state.fault_out;
  assign o_clock_fault = state.clock_fault;

  // ==========================================================================
  // Checks.
  // ==========================================================================
  // Reset leaves the widest window selected and the monitor armed.
  chk_reset_defaults: assert property (@(posedge i_sys_clk) // R15
    $fell(i_reset) |-> state.win_sel == 2'h3 && state.cmon_en)
    else $error("reset defaults wrong");

  // A second service before the lower limit must fault.
  chk_early_service: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R10
    service_wr && i_watchdog_option && state.first_done && !state.lower_open && !state.wd_fault
    |=> state.wd_fault)
    else $error("early service not flagged");

  // Once the first service is taken the settings never change again.
  chk_settings_locked: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R13
    state.first_done |=> $stable(state.win_sel) && $stable(state.cmon_en))
    else $error("settings changed after first service");

  // A later service with a different window select must fault.
  chk_mismatch_fault: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R14
    service_wr && i_watchdog_option && state.first_done && !state.wd_fault
    && i_wdata[WIN_MSB:WIN_LSB] != state.win_sel |=> state.wd_fault)
    else $error("window mismatch not flagged");

  // The key pattern never shows on the read port.
  chk_key_hidden: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R16
    i_read && i_addr == ADDR_SERVICE |=> o_rdata[5:1] == 5'h00)
    else $error("key read back");

  // A valid service restarts both limit counters.
  chk_service_restart: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R17
    valid_service && i_watchdog_option |=> state.upper_limit_counter == 17'h0 && !state.lower_open)
    else $error("service did not restart counters");

  // Reaching the upper limit drives the fault pin in the next cycle.
  chk_upper_expiry: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R18
    i_watchdog_option && upper_expired |=> o_watchdog_fault_output)
    else $error("expiry not flagged");

  // With the feature deselected no watchdog fault can stand.
  chk_option_off: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R12
    !i_watchdog_option |=> !state.wd_fault)
    else $error("fault while option off");

  // The lower window opens on the tick that completes 2048 counts.
  chk_lower_window: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R4
    $rose(state.lower_open) |-> $past(state.lower_limit_counter) == 12'h7ff)
    else $error("lower limit count wrong");

  // A disabled monitor never holds a clock fault.
  chk_monitor_off: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R7
    !state.cmon_en |-> !state.clock_fault)
    else $error("monitor fault while disabled");

  // A first write with a wrong key faults and leaves the settings open.
  chk_first_key: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R3
    service_wr && i_watchdog_option && !state.first_done && !state.wd_fault
    && i_wdata[KEY_MSB:KEY_LSB] != KEY_VALUE |=> state.wd_fault && !state.first_done)
    else $error("wrong first key not flagged");

  // A keyed first write stores the window and monitor bits as written.
  chk_first_store: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R13
    service_wr && !state.first_done && !state.wd_fault && i_wdata[KEY_MSB:KEY_LSB] == KEY_VALUE
    |=> state.first_done && {state.win_sel, 5'h00, state.cmon_en} == ($past(i_wdata) & 8'hc1))
    else $error("first service settings not stored");

  // Each select value doubles the upper limit, starting from 8k ticks.
  chk_upper_decode: assert property (@(posedge i_sys_clk) // R5
    upper_limit == (17'h02000 << state.win_sel))
    else $error("upper limit decode wrong");

  // The upper counter stops at the selected limit instead of wrapping.
  chk_upper_saturate: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R9
    state.upper_limit_counter <= upper_limit)
    else $error("upper counter ran past its limit");

  // Without an idle tick the upper counter either holds or restarts.
  chk_tick_source: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R6 R8
    !idle_tick |=> $stable(state.upper_limit_counter) || state.upper_limit_counter == 17'h00000)
    else $error("upper counter moved without a tick");

  // The lower counter moves one step per tick until the window opens.
  chk_lower_step: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R4 R9
    idle_tick && i_watchdog_option && !state.lower_open && !valid_service
    |=> state.lower_limit_counter == $past(state.lower_limit_counter) + 12'h001)
    else $error("lower counter step wrong");

  // A watchdog fault holds for as long as the feature stays selected.
  chk_fault_sticky: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R18
    state.wd_fault && i_watchdog_option |=> state.wd_fault)
    else $error("fault dropped without reset");

  // The pin carries either fault, registered in the same cycle as the flags.
  chk_fault_pin: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R11 R18
    o_watchdog_fault_output == (state.wd_fault || state.clock_fault))
    else $error("fault pin does not follow the flags");

  // A service during a standing fault changes none of the settings.
  chk_fault_ignores: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R14
    service_wr && state.wd_fault |=> $stable(state.win_sel) && $stable(state.first_done))
    else $error("service accepted during a fault");

  // Every instruction-clock rising edge restarts the monitor and clears its fault.
  chk_monitor_restart: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R11
    instr_rise |=> state.cmon_count == CMON_COUNT_ZERO && !state.clock_fault)
    else $error("monitor not restarted by a clock edge");

  // Read data drop back to zero in every cycle without a read strobe.
  chk_read_idle: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R16
    !i_read |=> o_rdata == 8'h00)
    else $error("read data stood too long");
endmodule : wwd_core

// ### tb/test_windowed_watchdog_clock_monitor.sv
`timescale 1ns/1ps
module test_windowed_watchdog_clock_monitor;
  import wwd_pkg::*;
  // ==========================================================================
  // Stimulus signals and the design instance.
  // ==========================================================================
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_watchdog_option = 1'b1;
  logic i_low_speed_mode = 1'b0;
  logic i_instr_clk = 1'b0;
  logic i_lowspeed_clk = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_write = 1'b0;
  logic i_read = 1'b0;
  logic [7:0] o_rdata;
  logic o_watchdog_fault_output;
  logic o_clock_fault;
  logic [1:0] phase = 2'h0;
  logic run_ls = 1'b1;
  int fails = 0;
  int cmp_count = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  // Idle tick sources with a four-cycle period, so each level lasts long enough for the synchroniser.
  always @(posedge i_sys_clk) begin
    phase <= phase + 2'h1;
    i_instr_clk <= phase[1];
    i_lowspeed_clk <= phase[1] & run_ls;
  end

  wwd_core dut (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_watchdog_option(i_watchdog_option),
    .i_low_speed_mode(i_low_speed_mode),
    .i_instr_clk(i_instr_clk),
    .i_lowspeed_clk(i_lowspeed_clk),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_write(i_write),
    .i_read(i_read),
    .o_rdata(o_rdata),
    .o_watchdog_fault_output(o_watchdog_fault_output),
    .o_clock_fault(o_clock_fault)
  );

  // ==========================================================================
  // Bus, compare and closing tasks.
  // ==========================================================================
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_flag

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_write <= 1'b1;
    @(posedge i_sys_clk);
    i_write <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are sampled just after that edge.
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_sys_clk);
    i_read <= 1'b0;
    #1;
    chk_byte(o_rdata, exp);
  endtask : rd_chk

  task automatic ticks(input int n);
    repeat (n * 4) @(posedge i_sys_clk);
  endtask : ticks

  // The fault is sticky, so a fixed settling time of a few cycles is enough.
  task automatic settle_flag(input logic exp);
    repeat (8) @(posedge i_sys_clk);
    #1;
    chk_flag(o_watchdog_fault_output, exp);
  endtask : settle_flag

  task automatic restart(input logic opt, input logic ls);
    i_watchdog_option <= opt;
    i_low_speed_mode <= ls;
    i_reset <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    i_reset <= 1'b0;
  endtask : restart

  // ==========================================================================
  // Test sequence.
  // ==========================================================================
  initial begin
    #1000000;
    fails++;
    $display("ERROR at %0t: run time limit used up", $time);
    test_done();
  end

  initial begin
    restart(1'b1, 1'b0);
    rd_chk(ADDR_SERVICE, 8'hc1);
    rd_chk(4'h7, 8'h00);
    wr(ADDR_STATUS, 8'h18);
    rd_chk(ADDR_SERVICE, 8'hc1);
    wr(ADDR_SERVICE, 8'h18);
    rd_chk(ADDR_SERVICE, 8'h00);
    settle_flag(1'b0);
    ticks(500);
    wr(ADDR_SERVICE, 8'h18);
    settle_flag(1'b1);
    chk_flag(o_clock_fault, 1'b0);
    $display("Test early service done");
    restart(1'b1, 1'b0);
    wr(ADDR_SERVICE, 8'h1a);
    settle_flag(1'b1);
    $display("Test wrong key done");
    restart(1'b1, 1'b0);
    wr(ADDR_SERVICE, 8'h59);
    rd_chk(ADDR_SERVICE, 8'h41);
    ticks(2100);
    wr(ADDR_SERVICE, 8'h58);
    settle_flag(1'b1);
    $display("Test field mismatch done");
    // With the low-speed clock stopped no idle ticks pass, so a late service still counts as early.
    restart(1'b1, 1'b1);
    run_ls <= 1'b0;
    wr(ADDR_SERVICE, 8'h18);
    ticks(2100);
    wr(ADDR_SERVICE, 8'h18);
    settle_flag(1'b1);
    rd_chk(ADDR_STATUS, 8'h05);
    run_ls <= 1'b1;
    $display("Test low-speed tick source done");
    restart(1'b0, 1'b0);
    wr(ADDR_SERVICE, 8'h1a);
    wr(ADDR_SERVICE, 8'h99);
    rd_chk(ADDR_SERVICE, 8'h81);
    settle_flag(1'b0);
    $display("Test watchdog deselected done");
    restart(1'b1, 1'b0);
    wr(ADDR_SERVICE, 8'h18);
    ticks(2060);
    wr(ADDR_SERVICE, 8'h18);
    settle_flag(1'b0);
    ticks(6200);
    wr(ADDR_SERVICE, 8'h18);
    settle_flag(1'b0);
    ticks(8150);
    settle_flag(1'b0);
    ticks(60);
    settle_flag(1'b1);
    $display("Test window limits done");
    test_done();
  end
endmodule : test_windowed_watchdog_clock_monitor
